// ===== dmmc_pkg.sv
// shared constants and types for the delta measurement mode control
package dmmc_pkg;

  // ************************************************************
  // modes and formats
  // ************************************************************
  typedef enum logic [1:0] {DMMC_NONE, DMMC_VOLT, DMMC_TIME, DMMC_RECIP} dmmc_mode_e;
  typedef enum logic [2:0] {
    DMMC_FMT_OFF, DMMC_FMT_VOLT, DMMC_FMT_VPCT, DMMC_FMT_TIME,
    DMMC_FMT_TRATIO, DMMC_FMT_FREQ, DMMC_FMT_PHASE
  } dmmc_fmt_e;
  typedef enum logic [1:0] {DMMC_DISP_A, DMMC_DISP_INTEN, DMMC_DISP_ALT, DMMC_DISP_BONLY} dmmc_disp_e;
  typedef enum logic [1:0] {DMMC_BT_IDLE, DMMC_BT_GATHER, DMMC_BT_RELEASE} dmmc_btn_e;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int DMMC_AW = 12;
  localparam logic [11:0] DMMC_ADDR_CTRL = 12'h000;
  localparam logic [11:0] DMMC_ADDR_STAT = 12'h004;
  localparam logic [11:0] DMMC_ADDR_POS = 12'h008;
  localparam logic [11:0] DMMC_ADDR_VERN = 12'h00c;
  localparam int DMMC_CTRL_AFTER_LSB = 0;
  localparam int DMMC_CTRL_SIZE_LSB = 8;
  localparam logic [7:0] DMMC_CTRL_AFTER_RST = 8'h10;
  localparam logic [3:0] DMMC_CTRL_SIZE_RST = 4'h8;
  localparam int DMMC_POS_LSB = 16;
  localparam int DMMC_VERN_LSB = 16;

  // ************************************************************
  // widths, scales, timing
  // ************************************************************
  localparam int DMMC_POS_W = 10;
  localparam int DMMC_VAR_W = 8;
  localparam int DMMC_KNOBS = 4;
  localparam int DMMC_K_REF = 0;
  localparam int DMMC_K_DELTA = 1;
  localparam int DMMC_K_VERN = 2;
  localparam int DMMC_K_HPOS = 3;
  localparam int DMMC_CH_ADD = 2;
  localparam logic [3:0] DMMC_FINE_STEP = 4'h1;
  localparam logic [8:0] DMMC_PCT_FULL = 9'h064;
  localparam logic [8:0] DMMC_DEG_FULL = 9'h168;
  localparam logic [2:0] DMMC_FULL_DIV = 3'h5;
  localparam logic [3:0] DMMC_EXP_KHZ = 4'h3;
  localparam logic [3:0] DMMC_EXP_MHZ = 4'h6;
  localparam logic [3:0] DMMC_EXP_GHZ = 4'h9;
  localparam int DMMC_CLK_NS = 40;
  localparam int DMMC_COIN_NS = 20000000;
  localparam int DMMC_COIN_CYC = DMMC_COIN_NS / DMMC_CLK_NS;

endpackage

// ===== dmmc_knob_res.sv
// fine/coarse resolution stepping for one positioning control
`timescale 1ns/1ns
module dmmc_knob_res (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic up,
  input wire logic dn,
  input wire logic [7:0] coarse_after,
  input wire logic [3:0] coarse_size,
  output logic step_up,
  output logic step_dn,
  output logic [3:0] step_amt
);
  import dmmc_pkg::*;

  typedef struct packed {
    logic last_dn;
    logic [7:0] travel;
    logic up;
    logic dn;
    logic [3:0] amt;
  } dmmc_kst_s;

  dmmc_kst_s s_ff;
  dmmc_kst_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.up = 1'b0;
    nxt_s.dn = 1'b0;
    if (up ^ dn) begin
      nxt_s.up = up;
      nxt_s.dn = dn;
      nxt_s.last_dn = dn;
      if (dn != s_ff.last_dn) begin
        nxt_s.travel = 8'h00;
        nxt_s.amt = DMMC_FINE_STEP;
      end else begin
        if (s_ff.travel != 8'hff) begin
          nxt_s.travel = s_ff.travel + 8'h01;
        end
        nxt_s.amt = (s_ff.travel >= coarse_after) ? coarse_size : DMMC_FINE_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_ff <= '{last_dn: 1'b0, travel: 8'h00, up: 1'b0, dn: 1'b0, amt: DMMC_FINE_STEP};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign step_up = s_ff.up;
  assign step_dn = s_ff.dn;
  assign step_amt = s_ff.amt;
endmodule

// ===== dmmc_top.sv
// delta measurement mode selector with cursor, vernier and magnifier locked_difference_mode
`timescale 1ns/1ns
module dmmc_top #(
  parameter int COIN_CYC = dmmc_pkg::DMMC_COIN_CYC,
  parameter int POS_W = dmmc_pkg::DMMC_POS_W,
  parameter int VAR_W = dmmc_pkg::DMMC_VAR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dmmc_pkg::DMMC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_volt,
  input wire logic btn_time,
  input wire logic btn_mag,
  input wire logic b_knob_out,
  input wire logic [4:0] a_speed,
  input wire logic [4:0] b_speed,
  input wire logic locked_difference_mode_sel,
  input wire logic [4:0] trace_sel,
  input wire logic [4:0] chan_uncal,
  input wire logic [3:0] vdiv_ch1,
  input wire logic [3:0] vdiv_ch2,
  input wire logic vernier_detent,
  input wire logic [3:0] delay_time_exp,
  input wire logic [dmmc_pkg::DMMC_KNOBS-1:0] knob_up,
  input wire logic [dmmc_pkg::DMMC_KNOBS-1:0] knob_dn,
  output dmmc_pkg::dmmc_mode_e delta_mode,
  output logic err_no_volt_delay,
  output logic cursor_horiz,
  output logic cursor_vert,
  output logic dual_delay,
  output dmmc_pkg::dmmc_fmt_e readout_fmt,
  output logic [8:0] readout_full,
  output logic [1:0] freq_range,
  output logic [2:0] scale_chan,
  output dmmc_pkg::dmmc_disp_e disp_mode,
  output logic mag_a,
  output logic mag_b,
  output logic vern_to_b,
  output logic [POS_W-1:0] ref_pos,
  output logic [POS_W-1:0] delta_pos,
  output logic [POS_W-1:0] hpos,
  output logic [VAR_W-1:0] vern_a,
  output logic [VAR_W-1:0] vern_b
);
  import dmmc_pkg::*;

  localparam int CW = $clog2(COIN_CYC + 1);
  localparam logic [CW-1:0] COIN_LAST = CW'(COIN_CYC - 1);
  localparam logic [POS_W-1:0] POS_MAX = {POS_W{1'b1}};
  localparam logic [POS_W-1:0] POS_MID = {1'b1, {(POS_W-1){1'b0}}};
  localparam logic [VAR_W-1:0] VAR_MAX = {VAR_W{1'b1}};

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] coarse_after;
    logic [3:0] coarse_size;
    dmmc_btn_e btn_st;
    logic [CW-1:0] coin_cnt;
    logic seen_v;
    logic seen_t;
    logic b_out_q;
    logic locked_q;
    logic mag_q;
    logic mag_on;
    dmmc_mode_e mode;
    logic err;
    logic cur_h;
    logic cur_v;
    logic dual;
    dmmc_fmt_e fmt;
    logic [8:0] full;
    logic [1:0] frange;
    logic [2:0] sch;
    dmmc_disp_e disp;
    logic mag_a;
    logic mag_b;
    logic vern_b_sel;
    logic [POS_W-1:0] ref_p;
    logic [POS_W-1:0] del_p;
    logic [POS_W-1:0] hpos;
    logic [VAR_W-1:0] va;
    logic [VAR_W-1:0] vb;
  } dmmc_st_s;

  dmmc_st_s s_ff;
  dmmc_st_s nxt_s;

  logic [DMMC_KNOBS-1:0] k_up;
  logic [DMMC_KNOBS-1:0] k_dn;
  logic [3:0] k_amt [DMMC_KNOBS];

  // ************************************************************
  // resolution stepping, one per positioning control
  // ************************************************************
  genvar gk;
  generate
    for (gk = 0; gk < DMMC_KNOBS; gk++) begin : g_knob
      dmmc_knob_res u_res (
        .ref_clk(ref_clk),
        .reset(reset),
        .up(knob_up[gk]),
        .dn(knob_dn[gk]),
        .coarse_after(s_ff.coarse_after),
        .coarse_size(s_ff.coarse_size),
        .step_up(k_up[gk]),
        .step_dn(k_dn[gk]),
        .step_amt(k_amt[gk])
      );
    end
  endgenerate

  // saturating move of a position by one step
  function automatic logic [POS_W-1:0] pos_move(input logic [POS_W-1:0] p, input logic up,
                                                input logic dn, input logic [3:0] amt);
    logic [POS_W:0] sum;
    sum = {1'b0, p};
    if (up) begin
      sum = sum + (POS_W+1)'(amt);
      if (sum > {1'b0, POS_MAX}) begin
        sum = {1'b0, POS_MAX};
      end
    end else if (dn) begin
      sum = (sum < (POS_W+1)'(amt)) ? '0 : sum - (POS_W+1)'(amt);
    end
    return sum[POS_W-1:0];
  endfunction

  // true when a full step fits before the end of travel
  function automatic logic pos_fits(input logic [POS_W-1:0] p, input logic up,
                                    input logic [3:0] amt);
    logic [POS_W:0] room;
    room = up ? ({1'b0, POS_MAX} - {1'b0, p}) : {1'b0, p};
    return room >= (POS_W+1)'(amt);
  endfunction

  function automatic logic [VAR_W-1:0] var_move(input logic [VAR_W-1:0] v, input logic up,
                                                input logic dn, input logic [3:0] amt);
    logic [VAR_W:0] sum;
    sum = {1'b0, v};
    if (up) begin
      sum = sum + (VAR_W+1)'(amt);
      if (sum > {1'b0, VAR_MAX}) begin
        sum = {1'b0, VAR_MAX};
      end
    end else if (dn) begin
      sum = (sum < (VAR_W+1)'(amt)) ? '0 : sum - (VAR_W+1)'(amt);
    end
    return sum[VAR_W-1:0];
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic locked;
    logic faster;
    logic single;
    logic ev_v;
    logic ev_t;
    logic ev_b;
    logic pct;
    logic [2:0] first;
    logic acc;
    logic map_ok;
    nxt_s = s_ff;
    locked = (a_speed == b_speed) && !b_knob_out;
    faster = b_speed > a_speed;
    single = (trace_sel != 5'h00) && ((trace_sel & (trace_sel - 5'h01)) == 5'h00);
    ev_v = 1'b0;
    ev_t = 1'b0;
    ev_b = 1'b0;
    pct = 1'b0;
    first = 3'h0;
    acc = psel && penable && s_ff.pready;
    map_ok = 1'b0;

    // apb slave: answer in the first access cycle
    nxt_s.pready = psel && !penable;
    if (psel && !penable) begin
      map_ok = (paddr == DMMC_ADDR_CTRL) || (paddr == DMMC_ADDR_STAT) ||
               (paddr == DMMC_ADDR_POS) || (paddr == DMMC_ADDR_VERN);
      nxt_s.pslverr = !map_ok;
      nxt_s.prdata = 32'h0000_0000;
      case (paddr)
        DMMC_ADDR_CTRL: begin
          nxt_s.prdata[DMMC_CTRL_AFTER_LSB +: 8] = s_ff.coarse_after;
          nxt_s.prdata[DMMC_CTRL_SIZE_LSB +: 4] = s_ff.coarse_size;
        end
        DMMC_ADDR_STAT: begin
          nxt_s.prdata[14:0] = {s_ff.sch, s_ff.mag_b, s_ff.mag_a, s_ff.disp,
                                s_ff.frange, s_ff.fmt, s_ff.err, s_ff.mode};
        end
        DMMC_ADDR_POS: begin
          nxt_s.prdata[POS_W-1:0] = s_ff.ref_p;
          nxt_s.prdata[DMMC_POS_LSB +: POS_W] = s_ff.del_p;
        end
        DMMC_ADDR_VERN: begin
          nxt_s.prdata[VAR_W-1:0] = s_ff.va;
          nxt_s.prdata[DMMC_VERN_LSB +: VAR_W] = s_ff.vb;
        end
        default: begin
          nxt_s.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (acc && pwrite && paddr == DMMC_ADDR_CTRL) begin
      nxt_s.coarse_after = pwdata[DMMC_CTRL_AFTER_LSB +: 8];
      nxt_s.coarse_size = pwdata[DMMC_CTRL_SIZE_LSB +: 4];
    end

    // button coincidence decode; waits for release so a held pair fires once
    case (s_ff.btn_st)
      DMMC_BT_IDLE: begin
        if (btn_volt || btn_time) begin
          nxt_s.btn_st = DMMC_BT_GATHER;
          nxt_s.coin_cnt = '0;
          nxt_s.seen_v = btn_volt;
          nxt_s.seen_t = btn_time;
        end
      end
      DMMC_BT_GATHER: begin
        nxt_s.seen_v = s_ff.seen_v || btn_volt;
        nxt_s.seen_t = s_ff.seen_t || btn_time;
        nxt_s.coin_cnt = s_ff.coin_cnt + 1'b1;
        if ((nxt_s.seen_v && nxt_s.seen_t) || s_ff.coin_cnt >= COIN_LAST) begin
          ev_b = nxt_s.seen_v && nxt_s.seen_t;
          ev_v = nxt_s.seen_v && !nxt_s.seen_t;
          ev_t = nxt_s.seen_t && !nxt_s.seen_v;
          nxt_s.btn_st = DMMC_BT_RELEASE;
        end
      end
      DMMC_BT_RELEASE: begin
        if (!btn_volt && !btn_time) begin
          nxt_s.btn_st = DMMC_BT_IDLE;
        end
      end
      default: begin
        nxt_s.btn_st = DMMC_BT_IDLE;
      end
    endcase

    // delta function selection
    nxt_s.b_out_q = b_knob_out;
    nxt_s.locked_q = locked;
    if (ev_v || ev_t || ev_b || (b_knob_out != s_ff.b_out_q) || (locked && !s_ff.locked_q)) begin
      nxt_s.err = 1'b0;
    end
    if (ev_v) begin
      if (s_ff.mode == DMMC_VOLT) begin
        nxt_s.mode = DMMC_NONE;
      end else if (locked) begin
        nxt_s.mode = DMMC_VOLT;
      end else if (!s_ff.err) begin
        nxt_s.err = 1'b1;
      end
    end
    if (ev_t) begin
      nxt_s.mode = (s_ff.mode == DMMC_TIME) ? DMMC_NONE : DMMC_TIME;
    end
    if (ev_b) begin
      nxt_s.mode = (s_ff.mode == DMMC_RECIP) ? DMMC_NONE : DMMC_RECIP;
    end
    if (b_knob_out && !s_ff.b_out_q && s_ff.mode == DMMC_VOLT && !ev_t && !ev_b) begin
      nxt_s.mode = DMMC_NONE;
    end

    // horizontal display mode
    if (locked) begin
      nxt_s.disp = DMMC_DISP_A;
    end else if (b_knob_out) begin
      nxt_s.disp = faster ? DMMC_DISP_ALT : DMMC_DISP_INTEN;
    end else begin
      nxt_s.disp = DMMC_DISP_BONLY;
    end

    // cursors and readout
    nxt_s.cur_h = (nxt_s.mode == DMMC_VOLT) && locked;
    nxt_s.cur_v = (nxt_s.mode == DMMC_TIME || nxt_s.mode == DMMC_RECIP) && locked;
    nxt_s.dual = (nxt_s.mode == DMMC_TIME || nxt_s.mode == DMMC_RECIP) && !locked;
    for (int i = 4; i >= 0; i--) begin
      if (trace_sel[i]) begin
        first = 3'(i);
      end
    end
    nxt_s.sch = first;
    pct = chan_uncal[first] ||
          (trace_sel == (5'h01 << DMMC_CH_ADD) &&
           (vdiv_ch1 != vdiv_ch2 || chan_uncal[0] || chan_uncal[1]));
    nxt_s.full = 9'h000;
    case (nxt_s.mode)
      DMMC_VOLT: begin
        nxt_s.fmt = pct ? DMMC_FMT_VPCT : DMMC_FMT_VOLT;
        nxt_s.full = pct ? DMMC_PCT_FULL : 9'h000;
      end
      DMMC_TIME: begin
        if (single && locked && !vernier_detent) begin
          nxt_s.fmt = DMMC_FMT_TRATIO;
          nxt_s.full = DMMC_PCT_FULL;
        end else begin
          nxt_s.fmt = DMMC_FMT_TIME;
        end
      end
      DMMC_RECIP: begin
        if (single && locked && !vernier_detent) begin
          nxt_s.fmt = DMMC_FMT_PHASE;
          nxt_s.full = DMMC_DEG_FULL;
        end else begin
          nxt_s.fmt = DMMC_FMT_FREQ;
        end
      end
      default: begin
        nxt_s.fmt = DMMC_FMT_OFF;
      end
    endcase
    if (delay_time_exp >= DMMC_EXP_GHZ) begin
      nxt_s.frange = 2'h3;
    end else if (delay_time_exp >= DMMC_EXP_MHZ) begin
      nxt_s.frange = 2'h2;
    end else if (delay_time_exp >= DMMC_EXP_KHZ) begin
      nxt_s.frange = 2'h1;
    end else begin
      nxt_s.frange = 2'h0;
    end

    // magnifier
    nxt_s.mag_q = btn_mag;
    if (btn_mag && !s_ff.mag_q) begin
      nxt_s.mag_on = !s_ff.mag_on;
    end
    nxt_s.mag_b = nxt_s.mag_on;
    nxt_s.mag_a = nxt_s.mag_on && nxt_s.disp != DMMC_DISP_ALT;

    // positioning controls
    if (locked_difference_mode_sel && (k_up[DMMC_K_REF] || k_dn[DMMC_K_REF])) begin
      if (pos_fits(s_ff.ref_p, k_up[DMMC_K_REF], k_amt[DMMC_K_REF]) &&
          pos_fits(s_ff.del_p, k_up[DMMC_K_REF], k_amt[DMMC_K_REF])) begin
        nxt_s.ref_p = pos_move(s_ff.ref_p, k_up[DMMC_K_REF], k_dn[DMMC_K_REF],
                               k_amt[DMMC_K_REF]);
        nxt_s.del_p = pos_move(s_ff.del_p, k_up[DMMC_K_REF], k_dn[DMMC_K_REF],
                               k_amt[DMMC_K_REF]);
      end
    end else begin
      nxt_s.ref_p = pos_move(s_ff.ref_p, k_up[DMMC_K_REF], k_dn[DMMC_K_REF],
                             k_amt[DMMC_K_REF]);
    end
    if (k_up[DMMC_K_DELTA] || k_dn[DMMC_K_DELTA]) begin
      nxt_s.del_p = pos_move(s_ff.del_p, k_up[DMMC_K_DELTA], k_dn[DMMC_K_DELTA],
                             k_amt[DMMC_K_DELTA]);
    end
    nxt_s.hpos = pos_move(s_ff.hpos, k_up[DMMC_K_HPOS], k_dn[DMMC_K_HPOS], k_amt[DMMC_K_HPOS]);
    // delay positions stay put while the vernier turns
    nxt_s.vern_b_sel = !locked;
    if (locked) begin
      nxt_s.va = var_move(s_ff.va, k_up[DMMC_K_VERN], k_dn[DMMC_K_VERN], k_amt[DMMC_K_VERN]);
    end else begin
      nxt_s.vb = var_move(s_ff.vb, k_up[DMMC_K_VERN], k_dn[DMMC_K_VERN], k_amt[DMMC_K_VERN]);
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.coarse_after <= DMMC_CTRL_AFTER_RST;
      s_ff.coarse_size <= DMMC_CTRL_SIZE_RST;
      s_ff.btn_st <= DMMC_BT_IDLE;
      s_ff.mode <= DMMC_NONE;
      s_ff.fmt <= DMMC_FMT_OFF;
      s_ff.disp <= DMMC_DISP_A;
      s_ff.locked_q <= 1'b1;
      s_ff.ref_p <= POS_MID;
      s_ff.del_p <= POS_MID;
      s_ff.hpos <= POS_MID;
      s_ff.va <= VAR_MAX;
      s_ff.vb <= VAR_MAX;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign delta_mode = s_ff.mode;
  assign err_no_volt_delay = s_ff.err;
  assign cursor_horiz = s_ff.cur_h;
  assign cursor_vert = s_ff.cur_v;
  assign dual_delay = s_ff.dual;
  assign readout_fmt = s_ff.fmt;
  assign readout_full = s_ff.full;
  assign freq_range = s_ff.frange;
  assign scale_chan = s_ff.sch;
  assign disp_mode = s_ff.disp;
  assign mag_a = s_ff.mag_a;
  assign mag_b = s_ff.mag_b;
  assign vern_to_b = s_ff.vern_b_sel;
  assign ref_pos = s_ff.ref_p;
  assign delta_pos = s_ff.del_p;
  assign hpos = s_ff.hpos;
  assign vern_a = s_ff.va;
  assign vern_b = s_ff.vb;
endmodule

// ===== dmmc_properties.sv
// output relations of the delta mode control, bound to the top module
`timescale 1ns/1ns
module dmmc_chk
  import dmmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic b_knob_out,
  input dmmc_pkg::dmmc_mode_e delta_mode,
  input wire logic err_no_volt_delay,
  input wire logic cursor_horiz,
  input wire logic cursor_vert,
  input wire logic dual_delay,
  input dmmc_pkg::dmmc_fmt_e readout_fmt,
  input wire logic [8:0] readout_full,
  input wire logic vern_to_b,
  input wire logic [7:0] vern_a
);
  // ************************************************************
  // properties
  // ************************************************************
  // cursors and formats are derived from the next mode, so they change on the mode's edge
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_horiz_volt: assert property (cursor_horiz |-> delta_mode == DMMC_VOLT)
    else $error("horizontal cursors without voltage delta");
  chk_vert_time: assert property (cursor_vert |-> !dual_delay && delta_mode > DMMC_VOLT)
    else $error("vertical cursors without time delta");
  chk_delay_split: assert property (dual_delay |-> delta_mode > DMMC_VOLT)
    else $error("dual delay without time delta");
  chk_freq_recip: assert property (readout_fmt inside {DMMC_FMT_FREQ, DMMC_FMT_PHASE} |->
    delta_mode == DMMC_RECIP)
    else $error("frequency readout outside reciprocal mode");
  chk_phase_full: assert property (readout_fmt == DMMC_FMT_PHASE |-> readout_full == 9'h168)
    else $error("phase full scale wrong");
  chk_ratio_full: assert property (readout_fmt inside {DMMC_FMT_VPCT, DMMC_FMT_TRATIO} |->
    readout_full == 9'h064)
    else $error("ratio full scale wrong");
  chk_err_hold: assert property ($rose(err_no_volt_delay) |-> $stable(delta_mode))
    else $error("mode changed with delay error");
  chk_pull_cancel: assert property ($rose(b_knob_out) |-> ##[1:3] delta_mode != DMMC_VOLT)
    else $error("voltage delta kept after pull");
  chk_toggle_clear: assert property ($changed(b_knob_out) |-> ##[1:3] !err_no_volt_delay)
    else $error("error kept after knob toggle");
  chk_vern_b: assert property (vern_to_b && $past(vern_to_b) && $past(vern_to_b, 2) |->
    $stable(vern_a))
    else $error("a vernier moved while unlocked");
endmodule
bind dmmc_top dmmc_chk dmmc_chk_inst (.ref_clk, .reset, .b_knob_out, .delta_mode,
  .err_no_volt_delay, .cursor_horiz, .cursor_vert, .dual_delay, .readout_fmt, .readout_full,
  .vern_to_b, .vern_a);

// ===== dmmc_operator.sv
// operator model: presses front-panel buttons and turns knobs
`timescale 1ns/1ns
module dmmc_operator (
  input wire logic ref_clk,
  output logic btn_volt,
  output logic btn_time,
  output logic btn_mag,
  output logic [dmmc_pkg::DMMC_KNOBS-1:0] knob_up,
  output logic [dmmc_pkg::DMMC_KNOBS-1:0] knob_dn
);
  initial begin
    {btn_volt, btn_time, btn_mag, knob_up, knob_dn} = 11'h0;
  end
  // long release so the next press never lands in the lock-out
  task automatic press(input logic v, input logic t, input logic m);
    @(posedge ref_clk);
    btn_volt <= v;
    btn_time <= t;
    btn_mag <= m;
    repeat (2) @(posedge ref_clk);
    {btn_volt, btn_time, btn_mag} <= 3'h0;
    repeat (14) @(posedge ref_clk);
  endtask
  // one detent is a one-cycle pulse
  task automatic turn(input int k, input logic up);
    @(posedge ref_clk);
    knob_up[k] <= up;
    knob_dn[k] <= !up;
    @(posedge ref_clk);
    {knob_up, knob_dn} <= 8'h0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ===== dmmc_tb.sv
// self-checking bench for the delta measurement mode control
`timescale 1ns/1ns
module tb_top;
  import dmmc_pkg::*;
  logic ref_clk, reset, psel, penable, pwrite, b_knob_out, locked_difference_mode_sel, vernier_detent;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, btn_volt, btn_time, btn_mag, cursor_horiz, cursor_vert, dual_delay;
  logic err_no_volt_delay, mag_a, mag_b, vern_to_b;
  logic [4:0] a_speed, b_speed, trace_sel, chan_uncal;
  logic [3:0] vdiv_ch1, vdiv_ch2, delay_time_exp, knob_up, knob_dn;
  logic [8:0] readout_full;
  logic [1:0] freq_range;
  logic [2:0] scale_chan;
  logic [9:0] ref_pos, delta_pos, hpos;
  logic [7:0] vern_a, vern_b;
  dmmc_mode_e delta_mode;
  dmmc_fmt_e readout_fmt;
  dmmc_disp_e disp_mode;
  int err_count, n_tests, m_mode, m_err, m_h;
  bit [1:0] seq[12] = '{2, 2, 1, 1, 3, 2, 3, 3, 1, 3, 1, 3};

  // short coincidence window keeps each press brief
  dmmc_top #(.COIN_CYC(8)) dmmc_top_inst (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .btn_volt, .btn_time, .btn_mag, .b_knob_out, .a_speed,
    .b_speed, .locked_difference_mode_sel, .trace_sel, .chan_uncal, .vdiv_ch1, .vdiv_ch2, .vernier_detent,
    .delay_time_exp, .knob_up, .knob_dn, .delta_mode, .err_no_volt_delay, .cursor_horiz,
    .cursor_vert, .dual_delay, .readout_fmt, .readout_full, .freq_range, .scale_chan,
    .disp_mode, .mag_a, .mag_b, .vern_to_b, .ref_pos, .delta_pos, .hpos, .vern_a, .vern_b);
  dmmc_operator dmmc_operator_inst (.ref_clk, .btn_volt, .btn_time, .btn_mag, .knob_up,
    .knob_dn);

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // no local limit: only the watchdog ends a wait for pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
    check({pready, pslverr}, {1'b1, e});
    if (!w) check(prdata, d);
  endtask
  task automatic chk();
    int sc, f;
    logic lk, one;
    lk = !b_knob_out && a_speed == b_speed;
    one = lk && $countones(trace_sel) == 1 && !vernier_detent;
    sc = 0;
    for (int i = 4; i >= 0; i--)
      if (trace_sel[i]) sc = i;
    f = m_mode == 2 ? (one ? 4 : 3) : m_mode == 3 ? (one ? 6 : 5) : 0;
    if (m_mode == 1)
      f = chan_uncal[sc] || (trace_sel == 5'h04 &&
        (vdiv_ch1 != vdiv_ch2 || |chan_uncal[1:0])) ? 2 : 1;
    check(delta_mode, m_mode);
    check(err_no_volt_delay, m_err);
    check(readout_fmt, f);
    check(readout_full, f == 2 || f == 4 ? 100 : f == 6 ? 360 : 0);
    check(scale_chan, sc);
    check(freq_range, delay_time_exp / 3 > 3 ? 3 : delay_time_exp / 3);
    check(cursor_horiz, m_mode == 1 && lk);
    check(cursor_vert, m_mode > 1 && lk);
    check(dual_delay, m_mode > 1 && !lk);
  endtask
  task automatic ev(input bit v, input bit t);
    int n;
    n = v && t ? 3 : v ? 1 : 2;
    dmmc_operator_inst.press(v, t, 1'b0);
    if (n == 1 && m_mode != 1 && (b_knob_out || a_speed != b_speed))
      m_err = !m_err;
    else begin
      m_err = 0;
      m_mode = m_mode == n ? 0 : n;
    end
    chk();
  endtask
  task automatic setk(input logic o, input logic [4:0] bs);
    if (o && !b_knob_out && m_mode == 1) m_mode = 0;
    m_err = 0;
    @(posedge ref_clk);
    b_knob_out <= o;
    b_speed <= bs;
    repeat (5) @(posedge ref_clk);
    chk();
    check(disp_mode, !o && bs == a_speed ? 0 : o && bs == a_speed ? 1 : o ? 2 : 3);
    check(vern_to_b, o || bs != a_speed);
  endtask

  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    reset = 1;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {b_knob_out, locked_difference_mode_sel, vernier_detent, chan_uncal, vdiv_ch1, vdiv_ch2} = 16'h0;
    a_speed = 5'h04;
    b_speed = 5'h04;
    trace_sel = 5'h01;
    delay_time_exp = 4'h0;
    void'($urandom(32'h65f6));
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    repeat (3) @(posedge ref_clk);
    chk();
    apb(0, DMMC_ADDR_CTRL, 32'h0000_0810, 0);
    apb(0, 12'h0f0, 32'h0000_0000, 1);
    $display("test reset done");
    foreach (seq[i]) begin
      vernier_detent <= i[0];
      trace_sel <= i[0] ? 5'($urandom_range(1, 31)) : 5'h01 << $urandom_range(0, 4);
      chan_uncal <= 5'($urandom);
      vdiv_ch1 <= 4'($urandom_range(0, 1));
      vdiv_ch2 <= 4'($urandom_range(0, 1));
      delay_time_exp <= 4'($urandom_range(0, 12));
      ev(seq[i][1], seq[i][0]);
    end
    $display("test buttons done");
    ev(1, 0);
    setk(1, 5'h04);
    ev(1, 0);
    ev(1, 0);
    ev(1, 0);
    ev(0, 1);
    ev(1, 0);
    setk(0, 5'h04);
    setk(1, 5'h05);
    dmmc_operator_inst.press(0, 0, 1);
    check({mag_a, mag_b}, 2'h1);
    setk(0, 5'h05);
    ev(1, 0);
    setk(0, 5'h04);
    check(mag_a, 1'b1);
    $display("test lock and error done");
    locked_difference_mode_sel <= 0;
    dmmc_operator_inst.turn(1, 1);
    dmmc_operator_inst.turn(0, 1);
    check({ref_pos, delta_pos}, {10'h201, 10'h201});
    locked_difference_mode_sel <= 1;
    dmmc_operator_inst.turn(0, 1);
    check({ref_pos, delta_pos}, {10'h202, 10'h202});
    dmmc_operator_inst.turn(2, 0);
    check(vern_a, 8'hfe);
    setk(1, 5'h04);
    dmmc_operator_inst.turn(2, 0);
    check({vern_a, vern_b}, 16'hfefe);
    apb(0, DMMC_ADDR_POS, 32'h0202_0202, 0);
    apb(1, DMMC_ADDR_CTRL, 32'h0000_0402, 0);
    apb(0, DMMC_ADDR_CTRL, 32'h0000_0402, 0);
    m_h = 512;
    for (int k = 1; k <= 6; k++) begin
      dmmc_operator_inst.turn(3, 1);
      m_h += k > 2 ? 4 : 1;
    end
    check(hpos, m_h);
    dmmc_operator_inst.turn(3, 0);
    check(hpos, m_h - 1);
    $display("test knobs done");
    report_and_stop();
  end
endmodule
